// ---- hw/timer_common_pkg.sv ----
// package: register map, field positions and codes of the timer common functions block
package timer_common_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] common_ctrl_index = 12'hd01;
    localparam logic [13:0] addr_common_ctrl  = 14'h3404;   // index times four
    localparam logic [13:0] addr_irq_status   = 14'h3500;
    localparam logic [13:0] addr_irq_mask     = 14'h3504;
    localparam logic [13:0] addr_demod_state  = 14'h3508;
    localparam logic [7:0]  common_ctrl_reset = 8'h00;

    localparam int bit_mode   = 7;
    localparam int bit_sel    = 6;
    localparam int field_lo   = 4;
    localparam int sub_lo     = 2;
    localparam int bit_init8  = 1;
    localparam int bit_init16 = 0;

    // interrupt status bits
    localparam int irq_rise = 0;
    localparam int irq_fall = 1;
    localparam int irq_pin  = 2;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [1:0] logic_and  = 2'h0;
    localparam logic [1:0] logic_or   = 2'h1;
    localparam logic [1:0] logic_nor  = 2'h2;
    localparam logic [1:0] logic_nand = 2'h3;
    localparam logic [1:0] sub_normal = 2'h0;
    localparam logic [1:0] sub_alt    = 2'h1;
    localparam logic [1:0] edge_fall  = 2'h0;
    localparam logic [1:0] edge_rise  = 2'h1;
    localparam logic [1:0] edge_both  = 2'h2;
    localparam logic [1:0] filt_none  = 2'h0;
    localparam logic [1:0] filt_4     = 2'h1;
    localparam logic [1:0] filt_8     = 2'h2;

    localparam int          sclk_period_ns = 10;
    localparam int          filt_short_cycles = 4;
    localparam int          filt_long_cycles  = 8;
    localparam logic [3:0]  filt_short = 4'(filt_short_cycles);
    localparam logic [3:0]  filt_long  = 4'(filt_long_cycles);

    typedef enum logic [2:0] {
        out_idle    = 3'b001,
        out_hold    = 3'b010,
        out_running = 3'b100
    } wide_state_t;

endpackage

// ---- hw/glitch_if.sv ----
// interface: raw input into the glitch filter, clean level out
interface glitch_if;
    logic       raw;
    logic [1:0] sel;
    logic       clean;
    modport owner  (output raw, output sel, input clean);
    modport filter (input raw, input sel, output clean);
endinterface

// ---- hw/glitch_filter.sv ----
// glitch filter: holds the last accepted level until a new one is stable long enough
module glitch_filter
    import timer_common_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    glitch_if.filter  gf
);
    logic [3:0] stable_count;
    logic [3:0] limit;

    always_comb
    begin
        case (gf.sel)
            filt_4:  limit = filt_short;
            filt_8:  limit = filt_long;
            default: limit = 4'h0;
        endcase
    end

    // counts cycles the raw level has differed from the accepted one
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stable_count <= 4'h0;
            gf.clean     <= 1'b0;
        end
        else if (gf.raw == gf.clean)
            stable_count <= 4'h0;
        else if (stable_count >= limit)
        begin
            gf.clean     <= gf.raw;
            stable_count <= 4'h0;
        end
        else
            stable_count <= stable_count + 4'h1;
    end
endmodule // glitch_filter

// ---- hw/timer_common.sv ----
// timer common functions block with an AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite slave port.
module timer_common
    import timer_common_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        stop_recovery,
    input  wire logic [13:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [13:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        narrow_timer_en,
    input  wire logic        wide_timer_en,
    input  wire logic        narrow_timer_out,
    input  wire logic        wide_timer_out,
    input  wire logic        port_out_value,
    input  wire logic        irq_mask_reg_pin,
    input  wire logic        demod_pin_first,
    input  wire logic        demod_pin_second,
    output logic             combined_out_pin,
    output logic             narrow_pin_level,
    output logic             wide_pin_level,
    output logic             alternating_active,
    output logic             demod_level,
    output logic             pin_event_irq,
    output logic             irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]  common_timer_ctrl;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic        aw_held;
    logic        w_held;
    logic [13:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        wr_ok;
    logic        rd_ok;

    wire mode_demod = common_timer_ctrl[bit_mode];
    wire [1:0] field_hi = common_timer_ctrl[field_lo+1:field_lo];
    wire [1:0] field_sub = common_timer_ctrl[sub_lo+1:sub_lo];

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_bresp   = wr_ok ? 2'h0 : 2'h2;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 14'h0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            wr_ok   <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                wr_ok <= aw_addr == addr_common_ctrl || aw_addr == addr_irq_status
                         || aw_addr == addr_irq_mask || aw_addr == addr_demod_state;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    wire        lane0_wr = do_write && w_strb[0];
    wire [7:0]  wb       = w_data[7:0];
    wire        cw       = lane0_wr && aw_addr == addr_common_ctrl;

    // ------------------------------------------------------------
    // demodulation input path
    // ------------------------------------------------------------
    glitch_if gfi ();
    assign gfi.raw = common_timer_ctrl[bit_sel] ? demod_pin_second : demod_pin_first;
    assign gfi.sel = mode_demod ? field_sub : filt_none;

    glitch_filter u_filter
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .gf      (gfi.filter)
    );

    logic clean_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            clean_q <= 1'b0;
        else
            clean_q <= gfi.clean;
    end

    wire rise_raw = gfi.clean && !clean_q;
    wire fall_raw = !gfi.clean && clean_q;
    // reserved code 11 detects nothing
    wire rise_ev = mode_demod && rise_raw && (field_hi == edge_rise || field_hi == edge_both);
    wire fall_ev = mode_demod && fall_raw && (field_hi == edge_fall || field_hi == edge_both);

    // first pin events reach the pin interrupt in demodulation mode with the first pin selected and its mask bit set
    logic first_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            first_q       <= 1'b0;
            pin_event_irq <= 1'b0;
        end
        else
        begin
            first_q       <= demod_pin_first;
            pin_event_irq <= mode_demod && !common_timer_ctrl[bit_sel] && irq_mask_reg_pin
                             && (first_q != demod_pin_first);
        end
    end

    // ------------------------------------------------------------
    // common control register
    // ------------------------------------------------------------
    // stop recovery keeps the combine field; the other fields go to reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            common_timer_ctrl <= common_ctrl_reset;
        else if (stop_recovery)
            common_timer_ctrl <= {2'h0, field_hi, 4'h0};
        else
        begin
            if (cw)
            begin
                common_timer_ctrl[7:2] <= wb[7:2];
                if (!mode_demod)
                    common_timer_ctrl[1:0] <= wb[1:0];
                else
                    common_timer_ctrl[1:0] <= common_timer_ctrl[1:0] & ~wb[1:0];
            end
            if (mode_demod)
            begin
                // set beats a same-cycle clear
                if (rise_ev)
                    common_timer_ctrl[bit_init8] <= 1'b1;
                if (fall_ev)
                    common_timer_ctrl[bit_init16] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // transmit outputs
    // ------------------------------------------------------------
    wide_state_t wide_state;
    logic        wide_q;
    logic        comb;

    // submode write to normal or alternating parks output until the timer counts
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wide_state <= out_idle;
        else
        begin
            case (wide_state)
                out_idle, out_running:
                begin
                    if (cw && !mode_demod && !wb[3])
                        wide_state <= out_hold;
                    else if (wide_timer_en)
                        wide_state <= out_running;
                    else
                        wide_state <= out_idle;
                end
                out_hold:
                    if (wide_timer_en && !(cw && !wb[3]))
                        wide_state <= out_running;
                default:
                    wide_state <= out_idle;
            endcase
        end
    end

    always_comb
    begin
        if (field_sub[1])
            wide_q = 1'b0;
        else if (wide_state != out_running || !wide_timer_en)
            wide_q = !common_timer_ctrl[bit_init16];
        else
            wide_q = wide_timer_out;
    end

    wire narrow_q = narrow_timer_en ? narrow_timer_out : !common_timer_ctrl[bit_init8];

    always_comb
    begin
        case (field_hi)
            logic_and:  comb = narrow_q & wide_q;
            logic_or:   comb = narrow_q | wide_q;
            logic_nor:  comb = !(narrow_q | wide_q);
            logic_nand: comb = !(narrow_q & wide_q);
            default:    comb = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            combined_out_pin   <= 1'b0;
            narrow_pin_level   <= 1'b0;
            wide_pin_level     <= 1'b0;
            alternating_active <= 1'b0;
            demod_level        <= 1'b0;
        end
        else
        begin
            combined_out_pin   <= (!mode_demod && common_timer_ctrl[bit_sel]) ? comb : port_out_value;
            narrow_pin_level   <= mode_demod ? 1'b0 : narrow_q;
            wide_pin_level     <= mode_demod ? 1'b0 : wide_q;
            alternating_active <= !mode_demod && field_sub == sub_alt;
            demod_level        <= gfi.clean;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    wire [2:0] events = {pin_event_irq, fall_ev, rise_ev};
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status <= 3'h0;
            irq_mask   <= 3'h0;
        end
        else
        begin
            irq_status <= (irq_status & ~((lane0_wr && aw_addr == addr_irq_status) ? wb[2:0] : 3'h0))
                          | events;
            if (lane0_wr && aw_addr == addr_irq_mask)
                irq_mask <= wb[2:0];
        end
    end
    assign irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp   = rd_ok ? 2'h0 : 2'h2;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            rd_ok        <= 1'b0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            rd_ok        <= 1'b1;
            case (s_axi_araddr)
                addr_common_ctrl: s_axi_rdata <= {24'h0, common_timer_ctrl};
                addr_irq_status:  s_axi_rdata <= {29'h0, irq_status};
                addr_irq_mask:    s_axi_rdata <= {29'h0, irq_mask};
                addr_demod_state: s_axi_rdata <= {30'h0, gfi.clean, wide_state == out_running};
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    rd_ok       <= 1'b0;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule // timer_common

// ---- verification/pin_model.sv ----
// partner model: the two demodulator input pins, pulsed for a chosen width
module pin_model
(
    input  wire logic       aclk,
    input  wire logic       go,
    input  wire logic       which,
    input  wire logic [4:0] width,
    output logic            demod_pin_first,
    output logic            demod_pin_second
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [4:0] left = 5'h00;
    logic       pick = 1'b0;

    always @(posedge aclk)
    begin
        if (go)
        begin
            left <= width;
            pick <= which;
        end
        else if (left != 5'h00)
            left <= left - 5'h01;
    end
    // the unused pin stays low so only the chosen one shows edges
    assign demod_pin_first  = (left != 5'h00) && !pick;
    assign demod_pin_second = (left != 5'h00) && pick;
endmodule // pin_model

// ---- verification/timer_common_checker.sv ----
// checker: port-level assertions for the timer common block
module timer_common_checker
    import timer_common_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        stop_recovery,
    input wire logic [13:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        narrow_timer_en,
    input wire logic        wide_timer_en,
    input wire logic        narrow_timer_out,
    input wire logic        wide_timer_out,
    input wire logic        irq_mask_reg_pin,
    input wire logic        combined_out_pin,
    input wire logic        narrow_pin_level,
    input wire logic        wide_pin_level,
    input wire logic        alternating_active,
    input wire logic        pin_event_irq
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [7:0] shadow;
    logic       base;
    logic       want;
    // copy of the control byte; trusted only for its transmit-mode bits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            shadow <= 8'h00;
        else if (stop_recovery)
            shadow <= shadow & 8'h30;
        else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == addr_common_ctrl)
            shadow <= s_axi_wdata[7:0];
    end
    assign base = (shadow[5] ^ shadow[4]) ? (narrow_pin_level | wide_pin_level) : (narrow_pin_level & wide_pin_level);
    assign want = base ^ shadow[5];

    sequence s_calm;
        $stable(shadow) && !stop_recovery && $stable({narrow_timer_en, wide_timer_en, narrow_timer_out, wide_timer_out});
    endsequence
    sequence s_aw_w;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    property p_combine;
        s_calm [*4] ##0 (!shadow[7] && shadow[6]) |-> combined_out_pin == want;
    endproperty
    property p_narrow_idle;
        s_calm [*4] ##0 (!shadow[7] && !narrow_timer_en) |-> narrow_pin_level == !shadow[1];
    endproperty
    property p_wide_idle;
        s_calm [*4] ##0 (!shadow[7] && !shadow[3] && !wide_timer_en) |-> wide_pin_level == !shadow[0];
    endproperty
    property p_force;
        s_calm [*4] ##0 (!shadow[7] && shadow[3]) |-> !wide_pin_level;
    endproperty
    property p_alt;
        s_calm [*4] |-> alternating_active == (!shadow[7] && shadow[3:2] == sub_alt);
    endproperty
    property p_demod_quiet;
        s_calm [*4] ##0 shadow[7] |-> !narrow_pin_level && !wide_pin_level;
    endproperty
    property p_pin_evt;
        pin_event_irq |-> $past(irq_mask_reg_pin);
    endproperty
    property p_write_ans;
        s_aw_w |-> ##[1:4] s_axi_bvalid;
    endproperty
    property p_read_ans;
        s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid;
    endproperty

    a_combine: assert property (p_combine) else $error("combined pin wrong");
    a_narrow_idle: assert property (p_narrow_idle) else $error("narrow idle level wrong");
    a_wide_idle: assert property (p_wide_idle) else $error("wide idle level wrong");
    a_force: assert property (p_force) else $error("wide output not forced low");
    a_alt: assert property (p_alt) else $error("alternating flag wrong");
    a_demod_quiet: assert property (p_demod_quiet) else $error("timer levels not low");
    a_pin_evt: assert property (p_pin_evt) else $error("pin event while masked");
    a_write_ans: assert property (p_write_ans) else $error("no write response");
    a_read_ans: assert property (p_read_ans) else $error("no read response");
endmodule // timer_common_checker

bind timer_common timer_common_checker i_check (.*);

// ---- verification/tb_top.sv ----
// testbench: timer common block with register bus, pin model and checks
module tb_top;
    import timer_common_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        aclk = 0, aresetn = 0, stop_recovery = 0;
    logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        narrow_timer_en = 0, wide_timer_en = 0, narrow_timer_out = 0, wide_timer_out = 0;
    logic        port_out_value = 0, irq_mask_reg_pin = 1, go = 0, which = 0, s;
    logic [4:0]  width = 0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs, bs, fl;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        demod_pin_first, demod_pin_second, combined_out_pin, narrow_pin_level;
    logic        wide_pin_level, alternating_active, demod_level, pin_event_irq, irq;
    int          err_total = 0, checks_done = 0, seed = 6, n_evt = 0, i, j;

    always #5 aclk = ~aclk;
    always @(posedge aclk) if (pin_event_irq === 1'b1) n_evt++;
    timer_common i_dut (.*);
    pin_model i_pins (.*);

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic hang;
        err_total++;
        end_sim();
    endtask
    // ready is looked at mid-cycle: it equals what the next rising edge samples
    task automatic axw(input logic [13:0] a, input logic [31:0] d);
        logic ta, tw, bv;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        repeat (40)
        begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            bv = s_axi_bvalid;
            bs = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
            if (bv === 1'b1)
            begin
                s_axi_bready <= 0;
                return;
            end
        end
        hang();
    endtask
    task automatic axr(input logic [13:0] a);
        logic ta, rv;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        repeat (40)
        begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 0;
            if (rv === 1'b1)
            begin
                s_axi_rready <= 0;
                return;
            end
        end
        hang();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic pulse(input logic p, input int w, output logic seen);
        @(posedge aclk);
        go <= 1;
        which <= p;
        width <= 5'(w);
        @(posedge aclk);
        go <= 0;
        seen = 0;
        repeat (w + 24)
        begin
            @(negedge aclk);
            seen |= demod_level;
        end
        // back onto the rising edge so later stimulus stays edge aligned
        @(posedge aclk);
    endtask
    function automatic logic mix(input int k);
        case (k[3:2])
            0: return k[1] & k[0];
            1: return k[1] | k[0];
            2: return !(k[1] | k[0]);
            default: return !(k[1] & k[0]);
        endcase
    endfunction

    initial
    begin
        tick(10);
        aresetn <= 1;
        axr(addr_common_ctrl);
        chk(rd, 0);
        axr(14'h0100);
        chk({rs, rd[29:0]}, 32'h80000000);
        axw(14'h0100, 0);
        chk(bs, 2);
        for (i = 0; i < 8; i++)
        begin
            j = $random(seed) & 32'h7f;
            axw(addr_common_ctrl, j);
            chk(bs, 0);
            axr(addr_common_ctrl);
            chk(rd, j);
        end
        axw(addr_common_ctrl, 32'h7f);
        stop_recovery <= 1;
        tick(1);
        stop_recovery <= 0;
        axr(addr_common_ctrl);
        chk(rd, 32'h30);
        // ---------------------------------------------------------
        // transmit mode: pin function, combining, idle levels
        // ---------------------------------------------------------
        for (i = 0; i < 16; i++)
        begin
            narrow_timer_en <= 0;
            wide_timer_en <= 0;
            axw(addr_common_ctrl, 32'h40 | (i & 12) << 2);
            narrow_timer_en <= 1;
            wide_timer_en <= 1;
            narrow_timer_out <= i[1];
            wide_timer_out <= i[0];
            tick(5);
            chk(combined_out_pin, mix(i));
        end
        axw(addr_common_ctrl, 0);
        for (j = 0; j < 2; j++)
        begin
            port_out_value <= j[0];
            tick(4);
            chk(combined_out_pin, j);
        end
        narrow_timer_en <= 0;
        wide_timer_en <= 0;
        for (i = 0; i < 16; i++)
        begin
            axw(addr_common_ctrl, i);
            tick(4);
            chk(narrow_pin_level, !i[1]);
            chk(wide_pin_level, i[3] ? 1'b0 : !i[0]);
            chk(alternating_active, i[3:2] == 1);
        end
        axw(addr_common_ctrl, 4);
        wide_timer_en <= 1;
        tick(2);
        chk(alternating_active, 1);
        axw(addr_common_ctrl, 0);
        tick(3);
        chk(alternating_active, 0);
        wide_timer_en <= 0;
        // ---------------------------------------------------------
        // demodulation mode: filter, edges, flags, interrupts
        // ---------------------------------------------------------
        axw(addr_irq_mask, 7);
        for (i = 0; i < 3; i++)
        begin
            axw(addr_common_ctrl, 32'ha3 | i << 2);
            if (i > 0)
            begin
                pulse(0, 4 * i, s);
                chk(s, 0);
            end
            pulse(0, 4 * i + 1, s);
            chk(s, 1);
        end
        for (i = 0; i < 3; i++)
        begin
            fl = 2'(i + 1);
            axw(addr_irq_status, 7);
            axw(addr_common_ctrl, 32'h83 | i << 4);
            pulse(0, 3, s);
            axw(addr_common_ctrl, 32'h80 | i << 4);
            axr(addr_common_ctrl);
            chk(rd[1:0], fl);
            axr(addr_irq_status);
            chk(rd[2:0], {1'b1, fl[0], fl[1]});
            chk(irq, 1);
        end
        axw(addr_common_ctrl, 32'ha3);
        axr(addr_common_ctrl);
        chk(rd[1:0], 0);
        axw(addr_irq_mask, 0);
        tick(2);
        chk(irq, 0);
        axw(addr_irq_mask, 7);
        tick(2);
        chk(irq, 1);
        axw(addr_irq_status, 7);
        tick(2);
        chk(irq, 0);
        axw(addr_common_ctrl, 32'he3);
        j = n_evt;
        pulse(1, 3, s);
        chk(s, 1);
        pulse(0, 3, s);
        chk(s, 0);
        chk(n_evt, j);
        axw(addr_common_ctrl, 32'ha3);
        pulse(0, 3, s);
        // one pin event for the rise and one for the fall
        chk(n_evt - j, 2);
        irq_mask_reg_pin <= 0;
        j = n_evt;
        pulse(0, 3, s);
        chk(n_evt, j);
        end_sim();
    end
endmodule // tb_top
